// *** include/timer16_regs.vh ***
// Contract
// - Capture flags with capture enable raise interrupt
// - Compare flags with compare enable raise interrupt
// - Wrap flag with overflow enable raises interrupt
// - Force bit copies level; sticky until reset
// - Compare match copies level to pin
// - Capture one on selected pin edge
// - Pin enable hands pin to compare
// - Single pulse mode triggered by capture one
// - PWM: compare one pulse, two period
// - Clock field: div4, div2, div8, external
// - Capture two on selected pin edge
// - External clock counts on selected edge
// - Capture flag one: set, two-step clear
// - Compare flag one: set, two-step clear
// - Wrap flag set on FFFF to 0000
// - Wrap flag cleared via counter low only
// - Capture flag two: set, two-step clear
// - Compare flag two: set, two-step clear
// - Status byte: five upper flags, rest zero
// - Second control register resets to zero
// - Pulse trigger reloads FFFC, outputs level two
// - PWM period end reloads FFFC, no interrupt
// - High compare write inhibits until low write
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
`define ADR_CTRL1     4'h0
`define ADR_CTRL2     4'h1
`define ADR_FLAGS     4'h2
`define ADR_CAP1_HI   4'h3
`define ADR_CAP1_LO   4'h4
`define ADR_CMP1_HI   4'h5
`define ADR_CMP1_LO   4'h6
`define ADR_CNT_HI    4'h7
`define ADR_CNT_LO    4'h8
`define ADR_ALT_HI    4'h9
`define ADR_ALT_LO    4'hA
`define ADR_CAP2_HI   4'hB
`define ADR_CAP2_LO   4'hC
`define ADR_CMP2_HI   4'hD
`define ADR_CMP2_LO   4'hE
`define C1_CAP_IRQ    7
`define C1_CMP_IRQ    6
`define C1_OVF_IRQ    5
`define C1_FORCE2     4
`define C1_FORCE1     3
`define C1_LVL2       2
`define C1_EDGE1      1
`define C1_LVL1       0
`define C2_PIN1_EN    7
`define C2_PIN2_EN    6
`define C2_ONE_PULSE  5
`define C2_PWM        4
`define C2_CLK_HI     3
`define C2_CLK_LO     2
`define C2_EDGE2      1
`define C2_EXT_EDGE   0
`define CLK_DIV4      2'h0
`define CLK_DIV2      2'h1
`define CLK_DIV8      2'h2
`define CLK_EXT       2'h3
`define CTRL1_RST     8'h00
`define CTRL2_RST     8'h00
`define DATA_RST      16'h0000
`define CNT_RELOAD    16'hFFFC
`define CNT_MAX       16'hFFFF
`endif

// *** hw/timer16_control_status.v ***
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "timer16_regs.vh"
module timer16_control_status (
   input  wire       i_mclk,
   input  wire       i_nrst,
   input  wire [3:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output reg  [7:0] o_rdata,
   input  wire       i_capture_in_pin_ch1,
   input  wire       i_capture_in_pin_ch2,
   input  wire       i_ext_count_clock_pin,
   output reg        o_compare_out_pin_ch1,
   output reg        o_compare_out_oe_ch1,
   output reg        o_compare_out_pin_ch2,
   output reg        o_compare_out_oe_ch2,
   output reg        o_timer_irq
);

   // Selected-edge detector on a synchronised level
   function edge_hit;
      input prev;
      input cur;
      input rise;
      begin
         edge_hit = rise ? (cur & ~prev) : (prev & ~cur);
      end
   endfunction

   reg  [7:0]  ctrl1_r;
   reg  [7:0]  ctrl2_r;
   reg  [4:0]  flag_r;
   reg  [4:0]  arm_r;
   reg  [15:0] cnt_r;
   reg  [15:0] cap1_r;
   reg  [15:0] cap2_r;
   reg  [15:0] cmp1_r;
   reg  [15:0] cmp2_r;
   reg  [1:0]  cmp_inh_r;
   reg  [1:0]  cap_inh_r;
   reg  [2:0]  pre_r;
   reg  [2:0]  sync1_r;
   reg  [2:0]  sync2_r;
   reg  [2:0]  prev_r;

   wire        acc = i_wr | i_rd;
   wire        one_pulse = ctrl2_r[`C2_ONE_PULSE];
   wire        pwm = ctrl2_r[`C2_PWM];
   wire [1:0]  clk_sel = ctrl2_r[`C2_CLK_HI:`C2_CLK_LO];

   // Three pins through two-flop synchronisers
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         prev_r  <= 3'h0;
      end
      else
      begin
         sync1_r <= {i_ext_count_clock_pin, i_capture_in_pin_ch2, i_capture_in_pin_ch1};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   wire cap1_evt = edge_hit(prev_r[0], sync2_r[0], ctrl1_r[`C1_EDGE1]);
   wire cap2_evt = edge_hit(prev_r[1], sync2_r[1], ctrl2_r[`C2_EDGE2]);
   wire ext_evt  = edge_hit(prev_r[2], sync2_r[2], ctrl2_r[`C2_EXT_EDGE]);

   // Timer clock tick selection
   reg tick;
   always @*
   begin
      case (clk_sel)
         `CLK_DIV4: tick = (pre_r[1:0] == 2'h3);
         `CLK_DIV2: tick = pre_r[0];
         `CLK_DIV8: tick = (pre_r == 3'h7);
         `CLK_EXT:  tick = ext_evt;
         default:   tick = 1'b0;
      endcase
   end

   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         pre_r <= 3'h0;
      else
         pre_r <= pre_r + 3'h1;
   end

   // Compare evaluated once per timer clock
   wire cmp1_hit = tick & (cnt_r == cmp1_r) & ~cmp_inh_r[0];
   wire cmp2_hit = tick & (cnt_r == cmp2_r) & ~cmp_inh_r[1];

   // Counter reload by pulse trigger or period end
   wire trig1  = one_pulse & cap1_evt;
   wire reload = trig1 | (pwm & cmp2_hit);
   wire wrap   = tick & ~reload & (cnt_r == `CNT_MAX);

   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         cnt_r <= `CNT_RELOAD;
      else if (reload)
         cnt_r <= `CNT_RELOAD;
      else if (tick)
         cnt_r <= cnt_r + 16'h0001;
   end

   // Bus decode
   wire wr_c1   = i_wr & (i_addr == `ADR_CTRL1);
   wire wr_c2   = i_wr & (i_addr == `ADR_CTRL2);
   wire st_acc  = acc & (i_addr == `ADR_FLAGS);
   wire wr_m1hi = i_wr & (i_addr == `ADR_CMP1_HI);
   wire wr_m1lo = i_wr & (i_addr == `ADR_CMP1_LO);
   wire wr_m2hi = i_wr & (i_addr == `ADR_CMP2_HI);
   wire wr_m2lo = i_wr & (i_addr == `ADR_CMP2_LO);
   wire rd_p1hi = i_rd & (i_addr == `ADR_CAP1_HI);
   wire rd_p1lo = i_rd & (i_addr == `ADR_CAP1_LO);
   wire rd_p2hi = i_rd & (i_addr == `ADR_CAP2_HI);
   wire rd_p2lo = i_rd & (i_addr == `ADR_CAP2_LO);

   // Low-byte accesses in flag order: cap1, cmp1, wrap, cap2, cmp2
   wire [4:0] lo_acc = {acc & (i_addr == `ADR_CAP1_LO),
                        acc & (i_addr == `ADR_CMP1_LO),
                        acc & (i_addr == `ADR_CNT_LO),
                        acc & (i_addr == `ADR_CAP2_LO),
                        acc & (i_addr == `ADR_CMP2_LO)};

   // Single pulse masks capture and compare one flags; PWM masks both compare flags
   wire [4:0] flag_set = {cap1_evt & ~one_pulse,
                          cmp1_hit & ~one_pulse & ~pwm,
                          wrap,
                          cap2_evt,
                          cmp2_hit & ~pwm};

   // Set wins over clear; clear needs an armed status access first
   wire [4:0] flag_nxt = flag_set | (flag_r & ~(arm_r & lo_acc));
   wire [4:0] arm_nxt  = st_acc ? ((arm_r & ~lo_acc) | flag_r) : (arm_r & ~lo_acc);

   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         flag_r <= 5'h00;
         arm_r  <= 5'h00;
      end
      else
      begin
         flag_r <= flag_nxt;
         arm_r  <= arm_nxt & flag_nxt;
      end
   end

   // Interrupt from enabled flag groups
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_timer_irq <= 1'b0;
      else
         o_timer_irq <= (ctrl1_r[`C1_CAP_IRQ] & (flag_nxt[4] | flag_nxt[1]))
                      | (ctrl1_r[`C1_CMP_IRQ] & (flag_nxt[3] | flag_nxt[0]))
                      | (ctrl1_r[`C1_OVF_IRQ] & flag_nxt[2]);
   end

   // Control registers; force bits only ever set
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ctrl1_r <= `CTRL1_RST;
         ctrl2_r <= `CTRL2_RST;
      end
      else
      begin
         if (wr_c1)
         begin
            ctrl1_r <= i_wdata | (ctrl1_r & 8'h18);
         end
         if (wr_c2)
         begin
            ctrl2_r <= i_wdata;
         end
      end
   end

   // Compare registers and high-byte inhibit
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cmp1_r    <= `DATA_RST;
         cmp2_r    <= `DATA_RST;
         cmp_inh_r <= 2'h0;
      end
      else
      begin
         if (wr_m1hi)
         begin
            cmp1_r[15:8] <= i_wdata;
            cmp_inh_r[0] <= 1'b1;
         end
         if (wr_m1lo)
         begin
            cmp1_r[7:0]  <= i_wdata;
            cmp_inh_r[0] <= 1'b0;
         end
         if (wr_m2hi)
         begin
            cmp2_r[15:8] <= i_wdata;
            cmp_inh_r[1] <= 1'b1;
         end
         if (wr_m2lo)
         begin
            cmp2_r[7:0]  <= i_wdata;
            cmp_inh_r[1] <= 1'b0;
         end
      end
   end

   // Capture registers; high read holds them until low read
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cap1_r    <= `DATA_RST;
         cap2_r    <= `DATA_RST;
         cap_inh_r <= 2'h0;
      end
      else
      begin
         if (cap1_evt & ~cap_inh_r[0])
            cap1_r <= cnt_r;
         if (cap2_evt & ~cap_inh_r[1])
            cap2_r <= cnt_r;
         if (rd_p1hi)
            cap_inh_r[0] <= 1'b1;
         else if (rd_p1lo)
            cap_inh_r[0] <= 1'b0;
         if (rd_p2hi)
            cap_inh_r[1] <= 1'b1;
         else if (rd_p2lo)
            cap_inh_r[1] <= 1'b0;
      end
   end

   // Output level latches; forced write takes the newly written level
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_compare_out_pin_ch1 <= 1'b0;
         o_compare_out_pin_ch2 <= 1'b0;
      end
      else
      begin
         if (wr_c1 & i_wdata[`C1_FORCE1])
            o_compare_out_pin_ch1 <= i_wdata[`C1_LVL1];
         else if (reload & (one_pulse | pwm))
            o_compare_out_pin_ch1 <= ctrl1_r[`C1_LVL2];
         else if (cmp1_hit)
            o_compare_out_pin_ch1 <= ctrl1_r[`C1_LVL1];
         if (wr_c1 & i_wdata[`C1_FORCE2])
            o_compare_out_pin_ch2 <= i_wdata[`C1_LVL2];
         else if (cmp2_hit)
            o_compare_out_pin_ch2 <= ctrl1_r[`C1_LVL2];
      end
   end

   // Pin ownership follows the enable bits
   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_compare_out_oe_ch1 <= 1'b0;
         o_compare_out_oe_ch2 <= 1'b0;
      end
      else
      begin
         o_compare_out_oe_ch1 <= wr_c2 ? i_wdata[`C2_PIN1_EN] : ctrl2_r[`C2_PIN1_EN];
         o_compare_out_oe_ch2 <= wr_c2 ? i_wdata[`C2_PIN2_EN] : ctrl2_r[`C2_PIN2_EN];
      end
   end

   // Read mux; data valid only in the cycle after the strobe
   reg [7:0] rd_mux;
   always @*
   begin
      case (i_addr)
         `ADR_CTRL1:   rd_mux = ctrl1_r;
         `ADR_CTRL2:   rd_mux = ctrl2_r;
         `ADR_FLAGS:   rd_mux = {flag_r, 3'h0};
         `ADR_CAP1_HI: rd_mux = cap1_r[15:8];
         `ADR_CAP1_LO: rd_mux = cap1_r[7:0];
         `ADR_CMP1_HI: rd_mux = cmp1_r[15:8];
         `ADR_CMP1_LO: rd_mux = cmp1_r[7:0];
         `ADR_CNT_HI:  rd_mux = cnt_r[15:8];
         `ADR_CNT_LO:  rd_mux = cnt_r[7:0];
         `ADR_ALT_HI:  rd_mux = cnt_r[15:8];
         `ADR_ALT_LO:  rd_mux = cnt_r[7:0];
         `ADR_CAP2_HI: rd_mux = cap2_r[15:8];
         `ADR_CAP2_LO: rd_mux = cap2_r[7:0];
         `ADR_CMP2_HI: rd_mux = cmp2_r[15:8];
         `ADR_CMP2_LO: rd_mux = cmp2_r[7:0];
         default:      rd_mux = 8'h00;
      endcase
   end

   always @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rd_mux;
      else
         o_rdata <= 8'h00;
   end

endmodule

// *** sim/timer16_control_status_assertions.sv ***
`timescale 1ns/1ns
module timer16_checker (
   input wire       i_mclk,
   input wire       i_nrst,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire       i_wr,
   input wire       i_rd,
   input wire [7:0] o_rdata,
   input wire       o_compare_out_pin_ch1,
   input wire       o_compare_out_oe_ch1,
   input wire       o_compare_out_pin_ch2,
   input wire       o_compare_out_oe_ch2,
   input wire       o_timer_irq
);
   reg [7:0] c1_r;
   reg [7:0] c2_r;
   // Shadow of both control bytes; force bits stick once set
   always @(posedge i_mclk or negedge i_nrst)
      if (!i_nrst)
      begin
         c1_r <= 8'h00;
         c2_r <= 8'h00;
      end
      else if (i_wr && i_addr == 4'h0)
         c1_r <= i_wdata | (c1_r & 8'h18);
      else if (i_wr && i_addr == 4'h1)
         c2_r <= i_wdata;
   default clocking dc @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);
   property p_flag_low;
      $past(i_rd) && $past(i_addr) == 4'h2 |-> o_rdata[2:0] == 3'h0;
   endproperty
   a_flag_low: assert property (p_flag_low) else $error("flag byte low bits set");
   property p_ctrl1_back;
      $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata == $past(c1_r);
   endproperty
   a_ctrl1_back: assert property (p_ctrl1_back) else $error("control one readback");
   property p_ctrl2_back;
      $past(i_rd) && $past(i_addr) == 4'h1 |-> o_rdata == $past(c2_r);
   endproperty
   a_ctrl2_back: assert property (p_ctrl2_back) else $error("control two readback");
   property p_oe_follow;
      i_wr && i_addr == 4'h1 |=> o_compare_out_oe_ch1 == c2_r[7] && o_compare_out_oe_ch2 == c2_r[6];
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("pin enable not taken");
   property p_oe_hold;
      !$past(i_wr) || $past(i_addr) != 4'h1 |-> $stable(o_compare_out_oe_ch1) && $stable(o_compare_out_oe_ch2);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");
   property p_force1;
      i_wr && i_addr == 4'h0 && i_wdata[3] |=> o_compare_out_pin_ch1 == c1_r[0];
   endproperty
   a_force1: assert property (p_force1) else $error("forced level one");
   property p_force2;
      i_wr && i_addr == 4'h0 && i_wdata[4] |=> o_compare_out_pin_ch2 == c1_r[2];
   endproperty
   a_force2: assert property (p_force2) else $error("forced level two");
   property p_irq_masked;
      (c1_r & 8'hE0) == 8'h00 && ($past(c1_r) & 8'hE0) == 8'h00 |-> !o_timer_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
   c_irq: cover property (o_timer_irq);
   c_force: cover property (i_wr && i_addr == 4'h0 && i_wdata[3]);
   c_flags: cover property ($past(i_rd) && $past(i_addr) == 4'h2 && o_rdata != 8'h00);
endmodule
bind timer16_control_status timer16_checker watch (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_compare_out_pin_ch1(o_compare_out_pin_ch1), .o_compare_out_oe_ch1(o_compare_out_oe_ch1),
   .o_compare_out_pin_ch2(o_compare_out_pin_ch2), .o_compare_out_oe_ch2(o_compare_out_oe_ch2),
   .o_timer_irq(o_timer_irq));

// *** sim/timer16_pins_model.sv ***
`timescale 1ns/1ns
module timer16_pins_model (
   input  wire i_mclk,
   output reg  o_cap_ch1,
   output reg  o_cap_ch2,
   output reg  o_ext_clk
);
   initial
   begin
      o_cap_ch1 = 1'b0;
      o_cap_ch2 = 1'b0;
      o_ext_clk = 1'b0;
   end
   // Pin change after dly edges; external clock stands still between calls
   task drive(input integer sel, input reg lvl, input integer dly);
   begin
      repeat (dly) @(posedge i_mclk);
      if (sel == 1)
         o_cap_ch1 <= lvl;
      else if (sel == 2)
         o_cap_ch2 <= lvl;
      else
         o_ext_clk <= lvl;
   end
   endtask
endmodule

// *** sim/timer16_control_status_test.sv ***
`timescale 1ns/1ns
module timer16_control_status_test;
   // Rows: control two value, counter advance over 16 cycles
   localparam [63:0] rows = 64'h0004_0408_0802_0C00;
   localparam [15:0] clr  = 16'hE648;
   reg         i_mclk  = 1'b0;
   reg         i_nrst  = 1'b0;
   reg  [3:0]  i_addr  = 4'h0;
   reg  [7:0]  i_wdata = 8'h00;
   reg         i_wr    = 1'b0;
   reg         i_rd    = 1'b0;
   reg  [7:0]  rdv;
   reg  [7:0]  v;
   reg  [15:0] row;
   wire [7:0]  o_rdata;
   wire        cap1, cap2, ext, pin1, oe1, pin2, oe2, irq;
   integer     mismatches = 0;
   integer     compares = 0;
   integer     cyc = 0;
   integer     i;
   integer     hc;
   always #10 i_mclk = ~i_mclk;
   timer16_control_status dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_capture_in_pin_ch1(cap1), .i_capture_in_pin_ch2(cap2),
      .i_ext_count_clock_pin(ext), .o_compare_out_pin_ch1(pin1), .o_compare_out_oe_ch1(oe1),
      .o_compare_out_pin_ch2(pin2), .o_compare_out_oe_ch2(oe2), .o_timer_irq(irq));
   timer16_pins_model pins (.i_mclk(i_mclk), .o_cap_ch1(cap1), .o_cap_ch2(cap2), .o_ext_clk(ext));
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task test_done;
   begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task wr(input [3:0] a, input [7:0] d);
   begin
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   end
   endtask
   task rd(input [3:0] a);
   begin
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 rdv = o_rdata;
   end
   endtask
   task tick(input integer n);
   begin
      repeat (n) @(posedge i_mclk);
      #1;
   end
   endtask
   // Cycles with compare pin one high over a window
   task meas(input integer n);
   begin
      hc = 0;
      repeat (n)
      begin
         @(posedge i_mclk);
         #1 hc = hc + pin1;
      end
   end
   endtask
   always @(posedge i_mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches = mismatches + 1;
         test_done;
      end
   end
   initial
   begin
      repeat (3) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd(4'h1);
      chk(rdv, 8'h00);
      for (i = 0; i < 4; i = i + 1)
      begin
         row = rows[16 * i +: 16];
         wr(4'h1, row[15:8]);
         rd(4'h8);
         v = rdv;
         tick(14);
         rd(4'h8);
         chk(rdv - v, row[7:0]);
         rd(4'h1);
         chk(rdv, row[15:8]);
      end
      wr(4'hF, 8'h5A);
      rd(4'hF);
      chk(rdv, 8'h00);
      wr(4'h1, 8'h0D);
      for (i = 0; i < 4; i = i + 1)
      begin
         if (i == 2)
            wr(4'h1, 8'h0C);
         rd(4'h8);
         v = rdv;
         pins.drive(0, ~ext, 3);
         tick(6);
         rd(4'h8);
         chk(rdv - v, {7'h00, i == 0 || i == 3});
      end
      rd(4'h2);
      chk(rdv, 8'h68);
      for (i = 0; i < 3; i = i + 1)
      begin
         wr(4'h0, 8'h20 << i);
         tick(2);
         chk({7'h00, irq}, {7'h00, i < 2});
      end
      wr(4'h0, 8'h82);
      pins.drive(1, 1'b1, 1);
      tick(6);
      chk({7'h00, irq}, 8'h01);
      rd(4'h2);
      chk(rdv, 8'hE8);
      rd(4'hA);
      rd(4'h2);
      chk(rdv, 8'hE8);
      for (i = 0; i < 4; i = i + 1)
         rd(clr[4 * i +: 4]);
      rd(4'h2);
      chk(rdv, 8'h00);
      pins.drive(1, 1'b0, 1);
      tick(6);
      rd(4'h2);
      chk(rdv, 8'h00);
      pins.drive(2, 1'b1, 1);
      pins.drive(2, 1'b0, 6);
      tick(6);
      rd(4'hC);
      rd(4'h2);
      chk(rdv, 8'h10);
      rd(4'hC);
      rd(4'h2);
      chk(rdv, 8'h00);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h02);
      wr(4'hD, 8'h00);
      wr(4'hE, 8'h40);
      wr(4'h0, 8'h46);
      wr(4'h1, 8'hA4);
      pins.drive(1, 1'b1, 1);
      meas(40);
      chk({7'h00, hc == 13 || hc == 14}, 8'h01);
      wr(4'h1, 8'h94);
      tick(140);
      meas(276);
      chk(hc[7:0], 8'h1C);
      rd(4'h2);
      chk({rdv[7:1], irq}, 8'h20);
      wr(4'h1, 8'hCC);
      tick(1);
      chk({6'h00, oe2, oe1}, 8'h03);
      wr(4'h0, 8'h1D);
      tick(1);
      chk({6'h00, pin2, pin1}, 8'h03);
      wr(4'h0, 8'h00);
      rd(4'h0);
      chk(rdv, 8'h18);
      chk({6'h00, pin2, pin1}, 8'h03);
      // Compare two set to the frozen count, high byte last: no match
      rd(4'h7);
      v = rdv;
      rd(4'h8);
      wr(4'hE, rdv);
      wr(4'hD, v);
      pins.drive(0, 1'b1, 1);
      pins.drive(0, 1'b0, 1);
      tick(6);
      rd(4'h2);
      chk({6'h00, pin2, rdv[3]}, 8'h02);
      // Low byte written last: compare live again
      rd(4'h7);
      v = rdv;
      rd(4'h8);
      wr(4'hD, v);
      wr(4'hE, rdv);
      pins.drive(0, 1'b1, 1);
      pins.drive(0, 1'b0, 1);
      tick(6);
      rd(4'h2);
      chk({6'h00, pin2, rdv[3]}, 8'h01);
      wr(4'h1, 8'h00);
      tick(1);
      chk({6'h00, oe2, oe1}, 8'h00);
      test_done;
   end
endmodule
